// *** hdl/rtb_rx_backplane.sv ***
// Receive backplane serial interface with AXI4-Lite registers
`timescale 1ns/100ps
`include "rtb_regs.svh"
module rtb_rx_backplane #(
  parameter int ADDR_W = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic reset_pin_n,
  input logic rx_bp_clock,
  input logic rx_bp_frame_pulse,
  input logic ch_wr_valid,
  input logic [4:0] ch_wr_num,
  input rtb_pkg::rtb_chan_type ch_wr_data,
  input logic f_bit,
  input logic [ADDR_W-1:0] s_awaddr,
  input logic s_awvalid,
  output logic s_awready,
  input logic [31:0] s_wdata,
  input logic [3:0] s_wstrb,
  input logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input logic s_bready,
  input logic [ADDR_W-1:0] s_araddr,
  input logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input logic s_rready,
  output logic rx_bp_pcm_out,
  output logic rx_bp_pcm_oe,
  output logic rx_bp_signaling_out,
  output logic rx_bp_signaling_oe
);

  initial begin
    if (ADDR_W < 4 || ADDR_W > 32) begin
      $error("rtb_rx_backplane: ADDR_W must lie in 4..32");
    end
  end

  logic clk_s;
  logic fp_s;
  logic pin_n_s;
  logic clk_d_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_do;
  logic dev_rst;
  logic soft_q;
  logic lock_q;
  logic slip_q;
  logic [15:0] frames_q;
  rtb_pkg::rtb_cfg_type cfg_q;
  rtb_pkg::rtb_cfg_type cfg_d;
  rtb_pkg::rtb_link_state_type state_q;
  logic [5:0] cnt_q;
  logic [9:0] pos_q;
  logic [9:0] nxt_pos;
  logic [9:0] last_pos;
  logic half_q;
  logic rise;
  logic fall;
  logic fp_hit;
  logic upd;
  logic [5:0] output_edge_count;
  logic start;
  logic step;
  logic slip_set;
  rtb_pkg::rtb_slot_type map;
  rtb_pkg::rtb_chan_type chan;
  logic pcm_d;
  logic sig_d;
  logic [31:0] rd_word;
  rtb_pkg::rtb_chan_type ch_mem [32];

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'h0};
    addr_ok = (w == ADDR_W'(`RTB_CFG_OFS)) ||
              (w == ADDR_W'(`RTB_CTRL_OFS)) ||
              (w == ADDR_W'(`RTB_STAT_OFS)) ||
              (w == ADDR_W'(`RTB_FRAMES_OFS));
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] ofs);
    is_reg = {a[ADDR_W-1:2], 2'h0} == ADDR_W'(ofs);
  endfunction

  function automatic logic [31:0] cfg_word(input rtb_pkg::rtb_cfg_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`RTB_CFG_RATE_LSB +: 2] = c.rate;
    w[`RTB_CFG_E1_BIT] = c.e1_not_t1_select;
    w[`RTB_CFG_FE_BIT] = c.frame_pulse_edge_select;
    w[`RTB_CFG_DE_BIT] = c.data_edge_select;
    w[`RTB_CFG_MAP_BIT] = c.map;
    w[`RTB_CFG_CMS_BIT] = c.clock_double_select;
    w[`RTB_CFG_BOFFEN_BIT] = c.bit_offset_enable;
    w[`RTB_CFG_BOFF_LSB +: 3] = c.bit_offset;
    w[`RTB_CFG_TSOFF_LSB +: 7] = c.timeslot_offset;
    cfg_word = w;
  endfunction

  function automatic rtb_pkg::rtb_cfg_type word_cfg(input logic [31:0] w);
    rtb_pkg::rtb_cfg_type c;
    c.rate = rtb_pkg::rtb_rate_type'(w[`RTB_CFG_RATE_LSB +: 2]);
    c.e1_not_t1_select = w[`RTB_CFG_E1_BIT];
    c.frame_pulse_edge_select = w[`RTB_CFG_FE_BIT];
    c.data_edge_select = w[`RTB_CFG_DE_BIT];
    c.map = w[`RTB_CFG_MAP_BIT];
    c.clock_double_select = w[`RTB_CFG_CMS_BIT];
    c.bit_offset_enable = w[`RTB_CFG_BOFFEN_BIT];
    c.bit_offset = w[`RTB_CFG_BOFF_LSB +: 3];
    c.timeslot_offset = w[`RTB_CFG_TSOFF_LSB +: 7];
    word_cfg = c;
  endfunction

  // Where a frame bit lands: stream position, channel and bit number
  function automatic rtb_pkg::rtb_slot_type slot_map(
      input rtb_pkg::rtb_cfg_type c, input logic [9:0] p);
    rtb_pkg::rtb_slot_type m;
    logic [6:0] k;
    logic [4:0] s;
    logic [9:0] q;
    m = '0;
    m.own = 1'h1;
    s = 5'h00;
    q = p - 10'h001;
    k = p[9:3] - c.timeslot_offset;
    m.bitn = p[2:0];
    unique case (c.rate)
      rtb_pkg::RATE_1544: begin
        if (p == 10'h000) begin
          m.fbit = 1'h1;
        end else begin
          m.ch = q[7:3];
          m.bitn = q[2:0];
        end
      end
      rtb_pkg::RATE_2048: s = k[4:0];
      rtb_pkg::RATE_4096: begin
        m.own = ~k[0];
        s = k[5:1];
      end
      rtb_pkg::RATE_8192: begin
        m.own = k[1:0] == 2'h0;
        s = k[6:2];
      end
    endcase
    // Offset zero lands this device in the first interleaved byte
    if (c.rate != rtb_pkg::RATE_1544) begin
      if (c.e1_not_t1_select) begin
        m.ch = s;
      end else if (!c.map) begin
        if (s[1:0] == 2'h0) begin
          m.fbit = (s == 5'h00) && (m.bitn == 3'h0);
          m.fill = ~m.fbit;
        end else begin
          m.ch = s - {2'h0, s[4:2]} - 5'h01;
        end
      end else if (s < 5'h18) begin
        m.ch = s;
      end else begin
        m.fbit = (s == 5'h1F) && (m.bitn == 3'h7);
        m.fill = ~m.fbit;
      end
    end
    slot_map = m;
  endfunction

  rtb_pin_sync #(
    .WIDTH(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_in({reset_pin_n, rx_bp_frame_pulse, rx_bp_clock}),
    .sync_out({pin_n_s, fp_s, clk_s})
  );

  // Pin reset restores all settings; software reset restores all but its own CTRL bit
  assign dev_rst = !aresetn || !pin_n_s || soft_q;
  assign wr_do = aw_hold_q && w_hold_q && !s_bvalid;

  // AXI write channels; address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'h0;
      w_hold_q <= 1'h0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_awready <= 1'h0;
      s_wready <= 1'h0;
      s_bvalid <= 1'h0;
      s_bresp <= `RTB_RESP_OKAY;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_hold_q <= 1'h1;
        awaddr_q <= s_awaddr;
        s_awready <= 1'h0;
      end else if (wr_do) begin
        aw_hold_q <= 1'h0;
      end else if (!aw_hold_q && !s_bvalid) begin
        s_awready <= 1'h1;
      end
      if (s_wvalid && s_wready) begin
        w_hold_q <= 1'h1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
        s_wready <= 1'h0;
      end else if (wr_do) begin
        w_hold_q <= 1'h0;
      end else if (!w_hold_q && !s_bvalid) begin
        s_wready <= 1'h1;
      end
      if (wr_do) begin
        s_bvalid <= 1'h1;
        s_bresp <= addr_ok(awaddr_q) ? `RTB_RESP_OKAY : `RTB_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'h0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_reg(s_araddr, `RTB_CFG_OFS)) begin
      rd_word = cfg_word(cfg_q);
    end else if (is_reg(s_araddr, `RTB_CTRL_OFS)) begin
      rd_word[`RTB_CTRL_SRST_BIT] = soft_q;
    end else if (is_reg(s_araddr, `RTB_STAT_OFS)) begin
      rd_word[`RTB_STAT_LOCK_BIT] = lock_q;
      rd_word[`RTB_STAT_RUN_BIT] = state_q == rtb_pkg::LS_RUN;
      rd_word[`RTB_STAT_SLIP_BIT] = slip_q;
      rd_word[`RTB_STAT_POS_LSB +: 10] = pos_q;
    end else if (is_reg(s_araddr, `RTB_FRAMES_OFS)) begin
      rd_word[15:0] = frames_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'h0;
      s_rvalid <= 1'h0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `RTB_RESP_OKAY;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_arready <= 1'h0;
        s_rvalid <= 1'h1;
        s_rdata <= rd_word;
        s_rresp <= addr_ok(s_araddr) ? `RTB_RESP_OKAY : `RTB_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'h0;
      end else if (!s_rvalid) begin
        s_arready <= 1'h1;
      end
    end
  end

  // Byte-lane merge; rate field freezes after its first write
  always_comb begin
    logic [31:0] w;
    w = cfg_word(cfg_q);
    for (int i = 0; i < 4; i++) begin
      if (wstrb_q[i]) begin
        w[8*i +: 8] = wdata_q[8*i +: 8];
      end
    end
    cfg_d = word_cfg(w);
    if (lock_q) begin
      cfg_d.rate = cfg_q.rate;
    end
  end

  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      cfg_q <= word_cfg(`RTB_CFG_RESET);
      lock_q <= 1'h0;
    end else if (ce && wr_do && is_reg(awaddr_q, `RTB_CFG_OFS)) begin
      cfg_q <= cfg_d;
      lock_q <= lock_q || wstrb_q[0];
    end
  end

  // Software reset bit survives its own reset so it can be cleared
  always_ff @(posedge aclk) begin
    if (!aresetn || !pin_n_s) begin
      soft_q <= 1'h0;
    end else if (ce && wr_do && is_reg(awaddr_q, `RTB_CTRL_OFS) &&
                 wstrb_q[0]) begin
      soft_q <= wdata_q[`RTB_CTRL_SRST_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && ch_wr_valid) begin
      ch_mem[ch_wr_num] <= ch_wr_data;
    end
  end

  // Link clock edges seen through the synchroniser
  assign rise = clk_s && !clk_d_q;
  assign fall = !clk_s && clk_d_q;
  assign fp_hit = (cfg_q.frame_pulse_edge_select ? rise : fall) && fp_s;
  assign upd = cfg_q.data_edge_select ? rise : fall;
  // Frame pulse-to-data edge count; double clock doubles each step
  assign output_edge_count = cfg_q.clock_double_select ?
               `RTB_CET_DBL_BASE + {1'h0, cfg_q.bit_offset, 2'h0} :
               `RTB_CET_PLAIN_BASE + {2'h0, cfg_q.bit_offset, 1'h0};

  always_comb begin
    unique case (cfg_q.rate)
      rtb_pkg::RATE_1544: last_pos = `RTB_LAST_1544;
      rtb_pkg::RATE_2048: last_pos = `RTB_LAST_2048;
      rtb_pkg::RATE_4096: last_pos = `RTB_LAST_4096;
      rtb_pkg::RATE_8192: last_pos = `RTB_LAST_8192;
    endcase
  end

  // Plain timing starts bit 0 on the pulse edge itself
  assign start = (fp_hit && !cfg_q.bit_offset_enable) ||
                 (state_q == rtb_pkg::LS_WAIT && (rise || fall) &&
                  cnt_q + 6'h01 == output_edge_count);
  assign step = state_q == rtb_pkg::LS_RUN && upd && !start &&
                (!cfg_q.clock_double_select || half_q);
  assign nxt_pos = (start || pos_q == last_pos) ? 10'h000 : pos_q + 10'h001;
  assign slip_set = start && state_q == rtb_pkg::LS_RUN && pos_q != last_pos;
  assign map = slot_map(cfg_q, nxt_pos);
  assign chan = ch_mem[map.ch];

  // Bit 0 of a slot goes out first, carrying the byte's MSB
  always_comb begin
    if (map.fbit) begin
      pcm_d = f_bit;
      sig_d = 1'h1;
    end else if (map.fill) begin
      pcm_d = 1'h1;
      sig_d = 1'h1;
    end else begin
      pcm_d = chan.pcm[3'h7 - map.bitn];
      sig_d = map.bitn[2] && chan.sig[~map.bitn[1:0]];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_d_q <= 1'h0;
    end else if (ce) begin
      clk_d_q <= clk_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      state_q <= rtb_pkg::LS_IDLE;
      cnt_q <= 6'h00;
      pos_q <= 10'h000;
      half_q <= 1'h0;
    end else if (ce) begin
      if (fp_hit && cfg_q.bit_offset_enable) begin
        state_q <= rtb_pkg::LS_WAIT;
        cnt_q <= 6'h00;
      end else if (start) begin
        state_q <= rtb_pkg::LS_RUN;
        pos_q <= nxt_pos;
        half_q <= 1'h0;
      end else if (state_q == rtb_pkg::LS_WAIT && (rise || fall)) begin
        cnt_q <= cnt_q + 6'h01;
      end else if (state_q == rtb_pkg::LS_RUN && upd) begin
        half_q <= cfg_q.clock_double_select && !half_q;
        if (step) begin
          pos_q <= nxt_pos;
        end
      end
    end
  end

  // Data pins float until the first frame is located
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      rx_bp_pcm_out <= 1'h0;
      rx_bp_signaling_out <= 1'h0;
      rx_bp_pcm_oe <= 1'h0;
      rx_bp_signaling_oe <= 1'h0;
    end else if (ce && (start || step)) begin
      rx_bp_pcm_out <= pcm_d;
      rx_bp_signaling_out <= sig_d;
      rx_bp_pcm_oe <= map.own;
      rx_bp_signaling_oe <= map.own;
    end
  end

  // Pulse off the expected frame boundary in plain timing only; set wins over clear
  always_ff @(posedge aclk) begin
    if (dev_rst) begin
      slip_q <= 1'h0;
      frames_q <= 16'h0000;
    end else if (ce) begin
      if (slip_set) begin
        slip_q <= 1'h1;
      end else if (wr_do && is_reg(awaddr_q, `RTB_STAT_OFS) &&
                   wstrb_q[0] && wdata_q[`RTB_STAT_SLIP_BIT]) begin
        slip_q <= 1'h0;
      end
      if (start) begin
        frames_q <= frames_q + 16'h0001;
      end
    end
  end

endmodule

// *** inc/rtb_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef RTB_REGS_SVH
`define RTB_REGS_SVH

`define RTB_CFG_OFS 8'h00
`define RTB_CTRL_OFS 8'h04
`define RTB_STAT_OFS 8'h08
`define RTB_FRAMES_OFS 8'h0C

`define RTB_CFG_RATE_LSB 0
`define RTB_CFG_E1_BIT 2
`define RTB_CFG_FE_BIT 3
`define RTB_CFG_DE_BIT 4
`define RTB_CFG_MAP_BIT 5
`define RTB_CFG_CMS_BIT 6
`define RTB_CFG_BOFFEN_BIT 7
`define RTB_CFG_BOFF_LSB 8
`define RTB_CFG_TSOFF_LSB 16
`define RTB_CTRL_SRST_BIT 0
`define RTB_STAT_LOCK_BIT 0
`define RTB_STAT_RUN_BIT 1
`define RTB_STAT_SLIP_BIT 2
`define RTB_STAT_POS_LSB 16

`define RTB_CFG_RESET 32'h0000_0000

`define RTB_CET_PLAIN_BASE 6'h03
`define RTB_CET_DBL_BASE 6'h04
`define RTB_LAST_1544 10'h0C0
`define RTB_LAST_2048 10'h0FF
`define RTB_LAST_4096 10'h1FF
`define RTB_LAST_8192 10'h3FF

`define RTB_RESP_OKAY 2'h0
`define RTB_RESP_SLVERR 2'h2

`endif

// *** inc/rtb_pkg.sv ***
// Types shared by the receive backplane design files
package rtb_pkg;

  typedef enum logic [1:0] {
    RATE_1544,
    RATE_2048,
    RATE_4096,
    RATE_8192
  } rtb_rate_type;

  typedef struct packed {
    logic [6:0] timeslot_offset;
    logic [2:0] bit_offset;
    logic bit_offset_enable;
    logic clock_double_select;
    logic map;
    logic data_edge_select;
    logic frame_pulse_edge_select;
    logic e1_not_t1_select;
    rtb_rate_type rate;
  } rtb_cfg_type;

  typedef struct packed {
    logic [7:0] pcm;
    logic [3:0] sig;
  } rtb_chan_type;

  typedef struct packed {
    logic own;
    logic fbit;
    logic fill;
    logic [4:0] ch;
    logic [2:0] bitn;
  } rtb_slot_type;

  typedef enum logic [1:0] {
    LS_IDLE,
    LS_WAIT,
    LS_RUN
  } rtb_link_state_type;

endpackage

// *** hdl/rtb_pin_sync.sv ***
// Two-stage synchroniser for pins from outside the aclk domain
`timescale 1ns/100ps
module rtb_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("rtb_pin_sync: WIDTH must be at least 1");
    end
  end

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (ce) begin
      meta_q <= pin_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** verif/rtb_rx_backplane_assertions.sv ***
// Port-level checker for the receive backplane block
`timescale 1ns/100ps
module rtb_rx_backplane_assertions #(
  parameter int ADDR_W = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic reset_pin_n,
  input logic rx_bp_clock,
  input logic rx_bp_frame_pulse,
  input logic s_awvalid,
  input logic s_awready,
  input logic s_wvalid,
  input logic s_wready,
  input logic s_bvalid,
  input logic s_arvalid,
  input logic s_arready,
  input logic s_rvalid,
  input logic rx_bp_pcm_out,
  input logic rx_bp_pcm_oe,
  input logic rx_bp_signaling_oe
);
  logic clk_pin_q;
  logic [3:0] since_q;
  logic seen_q;
  // Cycles since the link clock pin last moved
  always_ff @(posedge aclk) begin
    clk_pin_q <= rx_bp_clock;
    if (rx_bp_clock != clk_pin_q) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  // Pin reset is not cleared here: its sync lag would make false alarms
  always_ff @(posedge aclk) begin
    if (!aresetn) seen_q <= 1'b0;
    else if (rx_bp_frame_pulse) seen_q <= 1'b1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence pin_held;
    !reset_pin_n [*4];
  endsequence
  sequence pcm_moved;
    $changed(rx_bp_pcm_out) && rx_bp_pcm_oe && $past(rx_bp_pcm_oe);
  endsequence
  AST_OE_OFF_IN_RESET: assert property (disable iff (1'b0)
    !aresetn |=> !rx_bp_pcm_oe && !rx_bp_signaling_oe)
    else $error("Outputs driven during reset");
  AST_PIN_RESET_QUIETS: assert property (
    pin_held |-> ##[0:3] !rx_bp_pcm_oe)
    else $error("Reset pin did not release the data line");
  AST_BIT_AT_LINK_EDGE: assert property (
    pcm_moved |-> since_q <= 4'h5)
    else $error("Data changed away from a link clock edge");
  AST_BIT_STANDS: assert property (
    pcm_moved |=> ($stable(rx_bp_pcm_out) || !rx_bp_pcm_oe) [*6])
    else $error("Data bit shorter than a link clock period");
  AST_QUIET_BEFORE_PULSE: assert property (
    !seen_q |-> !rx_bp_pcm_oe && !rx_bp_signaling_oe)
    else $error("Outputs driven before any frame pulse");
  AST_BRESP_AFTER_WRITE: assert property (
    wr_taken |-> ##2 s_bvalid)
    else $error("Write response late");
  AST_READY_HELD_LOW: assert property (
    s_bvalid |-> !s_awready && !s_wready)
    else $error("Write accepted while response pending");
  AST_RDATA_AFTER_READ: assert property (
    s_arvalid && s_arready |=> s_rvalid)
    else $error("Read data late");
endmodule
bind rtb_rx_backplane rtb_rx_backplane_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .aclk, .aresetn, .reset_pin_n, .rx_bp_clock, .rx_bp_frame_pulse,
  .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_arvalid,
  .s_arready, .s_rvalid, .rx_bp_pcm_out, .rx_bp_pcm_oe, .rx_bp_signaling_oe);

// *** verif/rtb_bp_partner.sv ***
// Backplane-side model: link clock, frame pulse and bit capture
`timescale 1ns/100ps
module rtb_bp_partner (
  output logic rx_bp_clock,
  output logic rx_bp_frame_pulse,
  input logic rx_bp_pcm_out,
  input logic rx_bp_pcm_oe,
  input logic rx_bp_signaling_out,
  input logic go,
  input int first,
  input int step,
  output logic done
);
  logic cap_pcm [64];
  logic cap_oe [64];
  logic cap_sig [64];
  // Offset so link edges never coincide with an aclk edge
  initial begin
    rx_bp_clock = 1'b0;
    #7;
    forever #100 rx_bp_clock = ~rx_bp_clock;
  end
  initial begin
    int e;
    int n;
    rx_bp_frame_pulse = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge go);
      done = 1'b0;
      n = 0;
      @(posedge rx_bp_clock);
      rx_bp_frame_pulse <= 1'b1;
      @(posedge rx_bp_clock);
      rx_bp_frame_pulse <= 1'b0;
      e = 1;
      while (n < 64) begin
        // Sample on the edge opposite to the update edge
        if (e >= first && (e - first) % step == 0) begin
          // A released line has no pull: show it as the opposite level
          cap_pcm[n] = rx_bp_pcm_oe ? rx_bp_pcm_out : !rx_bp_pcm_out;
          cap_oe[n] = rx_bp_pcm_oe;
          cap_sig[n] = rx_bp_signaling_out;
          n++;
        end
        @(rx_bp_clock);
        e++;
      end
      done = 1'b1;
    end
  end
endmodule

// *** verif/rtb_rx_backplane_test.sv ***
// Self-checking bench for the receive backplane block
`timescale 1ns/100ps
`include "rtb_regs.svh"
module rtb_rx_backplane_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic reset_pin_n = 1'b1;
  logic ch_wr_valid = 1'b0;
  logic [4:0] ch_wr_num = 5'h00;
  rtb_pkg::rtb_chan_type ch_wr_data = '0;
  logic f_bit = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_arvalid = 1'b0;
  logic go = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, done;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic rx_bp_pcm_out, rx_bp_pcm_oe, rx_bp_signaling_out;
  logic rx_bp_signaling_oe, rx_bp_clock, rx_bp_frame_pulse;
  int first, step, n_mismatch, checks_done, cyc;
  rtb_pkg::rtb_chan_type chans [32];
  always #12.5 aclk = ~aclk;
  rtb_rx_backplane dut (
    .aclk, .aresetn, .ce(1'b1), .reset_pin_n, .rx_bp_clock,
    .rx_bp_frame_pulse, .ch_wr_valid, .ch_wr_num, .ch_wr_data, .f_bit,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hF), .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready(1'b1), .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready(1'b1),
    .rx_bp_pcm_out, .rx_bp_pcm_oe, .rx_bp_signaling_out, .rx_bp_signaling_oe);
  rtb_bp_partner bp (
    .rx_bp_clock, .rx_bp_frame_pulse, .rx_bp_pcm_out, .rx_bp_pcm_oe,
    .rx_bp_signaling_out, .go, .first, .step, .done);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw |= s_awready;
      w |= s_wready;
      s_awvalid <= !aw;
      s_wvalid <= !w;
    end
    do @(posedge aclk); while (!s_bvalid);
    r = s_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
  endtask
  // Expected line state for bit p of the frame; only stream 0 is ours
  function automatic void model(input logic [31:0] c, input int p,
      output logic eo, output logic ep, output logic es, output bit cs);
    int n, byt, b, slot, ch;
    n = c[1] ? (c[0] ? 4 : 2) : 1;
    byt = p / 8;
    b = (c[1:0] == 2'h0) ? (p + 7) % 8 : p % 8;
    slot = byt / n;
    eo = (byt % n) == 0;
    if (c[2]) ch = slot;
    else if (c[1:0] == 2'h0) ch = (p == 0) ? -1 : (p - 1) / 8;
    else if (c[5]) ch = (slot < 24) ? slot : -1;
    else ch = (slot % 4 == 0) ? -1 : slot - slot / 4 - 1;
    ep = (!c[2] && p == 0) ? f_bit : 1'b1;
    es = 1'b0;
    cs = ch >= 0;
    if (cs) ep = chans[ch].pcm[7 - b];
    if (cs && b >= 4) es = chans[ch].sig[7 - b];
  endfunction
  task automatic run_case(input logic [31:0] c, input int f, input int s);
    logic [31:0] d;
    logic [1:0] r;
    logic eo, ep, es;
    bit cs;
    wr(`RTB_CTRL_OFS, 32'h1, r);
    wr(`RTB_CTRL_OFS, 32'h0, r);
    rd(`RTB_CFG_OFS, d, r);
    check(d, `RTB_CFG_RESET);
    wr(`RTB_CFG_OFS, c, r);
    check(r, `RTB_RESP_OKAY);
    wr(`RTB_CFG_OFS, c ^ 32'h3, r);
    rd(`RTB_CFG_OFS, d, r);
    check(d, c);
    f_bit <= 1'($urandom);
    for (int i = 0; i < 32; i++) begin
      chans[i] = 12'($urandom);
      ch_wr_valid <= 1'b1;
      ch_wr_num <= 5'(i);
      ch_wr_data <= chans[i];
      @(posedge aclk);
    end
    ch_wr_valid <= 1'b0;
    first <= f;
    step <= s;
    go <= 1'b1;
    do @(posedge aclk); while (!done);
    go <= 1'b0;
    for (int p = 0; p < 64; p++) begin
      model(c, p, eo, ep, es, cs);
      check(bp.cap_oe[p], eo);
      if (eo) check(bp.cap_pcm[p], ep);
      if (eo && cs) check(bp.cap_sig[p], es);
    end
    rd(`RTB_FRAMES_OFS, d, r);
    check(d, 32'h1);
    rd(`RTB_STAT_OFS, d, r);
    check(d[2:0], 32'h3);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'hE899B3CB));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check(rx_bp_pcm_oe, 1'b0);
    wr(8'h10, 32'h0, r);
    check(r, `RTB_RESP_SLVERR);
    rd(8'h10, d, r);
    check(r, `RTB_RESP_SLVERR);
    run_case(32'h0000_0000, 1, 2);
    run_case(32'h0000_0001, 1, 2);
    run_case(32'h0000_0005, 1, 2);
    run_case(32'h0000_0006, 1, 2);
    run_case(32'h0000_0023, 1, 2);
    run_case(32'h0000_0007, 1, 2);
    run_case(32'h0000_0095, 4, 2);
    run_case(32'h0000_01C5, 9, 4);
    run_case(32'h0000_01DD, 8, 4);
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge aclk);
    check(rx_bp_pcm_oe, 1'b0);
    rd(`RTB_CFG_OFS, d, r);
    check(d, `RTB_CFG_RESET);
    give_verdict;
  end
endmodule
